// ==== hdl/can_acceptance_filter.sv ====
// Purpose: sixteen acceptance filters with APB register access
// Assumes: masks arrive as inputs; rx_valid marks one identifier per cycle
// Notes: match result registered one cycle after rx_valid
`timescale 1ns/10ps
module can_acceptance_filter (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire accept_filter_pkg::can_id_t mask0,
  input wire accept_filter_pkg::can_id_t mask1,
  input wire accept_filter_pkg::can_id_t mask2,
  input wire logic rx_valid,
  input wire accept_filter_pkg::can_id_t rx_id,
  output logic match_valid,
  output logic match_any,
  output logic [3:0] match_index,
  output logic [15:0] match_vector
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] mask_sel_low;
    logic [15:0] mask_sel_high;
    logic [31:0] rdata;
    logic valid;
    logic any;
    logic [3:0] index;
    logic [15:0] vector;
  } ctrl_t;

  ctrl_t st_r;
  ctrl_t st_nxt;
  // identifier storage has no reset, so it sits outside the reset struct
  logic [15:0] std_mem_r [accept_filter_pkg::num_filters];
  logic [15:0] ext_mem_r [accept_filter_pkg::num_filters];
  logic [31:0] sel_all;
  logic [15:0] hits;
  accept_filter_pkg::apb_req_t req;
  logic acc_wr;
  logic acc_rd;
  logic is_filter;
  logic [3:0] fidx;
  logic decoded;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  always_comb begin
    req = '{psel, penable, pwrite, paddr, pwdata};
    acc_wr = req.psel && req.penable && req.pwrite;
    acc_rd = req.psel && !req.penable && !req.pwrite; // read data latched in setup
    is_filter = (req.paddr[11:7] == 5'h00) && (req.paddr[1:0] == 2'h0);
    fidx = req.paddr[6:3];
    decoded = is_filter ||
              (req.paddr == accept_filter_pkg::mask_sel_low_addr) ||
              (req.paddr == accept_filter_pkg::mask_sel_high_addr) ||
              (req.paddr == accept_filter_pkg::match_status_addr);
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !decoded;
  assign prdata = st_r.rdata;

  // ----------------------------------------
  // per-filter compare
  // ----------------------------------------
  assign sel_all = {st_r.mask_sel_high, st_r.mask_sel_low};

  genvar g;
  generate
    for (g = 0; g < accept_filter_pkg::num_filters; g++) begin : g_flt
      filter_compare u_cmp (
        .std_reg(std_mem_r[g]),
        .ext_reg(ext_mem_r[g]),
        .mask_src(sel_all[2*g+1 -: 2]),
        .mask0(mask0),
        .mask1(mask1),
        .mask2(mask2),
        .rx_id(rx_id),
        .hit(hits[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // register writes
    if (acc_wr && req.paddr == accept_filter_pkg::mask_sel_low_addr) begin
      st_nxt.mask_sel_low = req.pwdata[15:0];
    end
    if (acc_wr && req.paddr == accept_filter_pkg::mask_sel_high_addr) begin
      st_nxt.mask_sel_high = req.pwdata[15:0];
    end
    // read data captured in the setup cycle so it is stable in access
    if (acc_rd) begin
      st_nxt.rdata = 32'h0000_0000;
      if (is_filter && !req.paddr[2]) begin
        st_nxt.rdata = {16'h0000, std_mem_r[fidx] & accept_filter_pkg::std_reg_write_mask};
      end else if (is_filter) begin
        st_nxt.rdata = {16'h0000, ext_mem_r[fidx]};
      end else if (req.paddr == accept_filter_pkg::mask_sel_low_addr) begin
        st_nxt.rdata = {16'h0000, st_r.mask_sel_low};
      end else if (req.paddr == accept_filter_pkg::mask_sel_high_addr) begin
        st_nxt.rdata = {16'h0000, st_r.mask_sel_high};
      end else if (req.paddr == accept_filter_pkg::match_status_addr) begin
        st_nxt.rdata = {st_r.vector, 10'h000, st_r.any, 1'b0, st_r.index};
      end
    end
    // match result; lowest numbered hit wins the index
    st_nxt.valid = rx_valid;
    if (rx_valid) begin
      st_nxt.vector = hits;
      st_nxt.any = |hits;
      st_nxt.index = 4'h0;
      for (int i = accept_filter_pkg::num_filters - 1; i >= 0; i--) begin
        if (hits[i]) begin
          st_nxt.index = 4'(i);
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.mask_sel_low <= accept_filter_pkg::mask_sel_reset;
      st_r.mask_sel_high <= accept_filter_pkg::mask_sel_reset;
    end else begin
      st_r <= st_nxt;
    end
  end

  // identifier storage; unimplemented bits kept at zero
  always_ff @(posedge clk_sys) begin
    if (acc_wr && is_filter && !req.paddr[2]) begin
      std_mem_r[fidx] <= req.pwdata[15:0] & accept_filter_pkg::std_reg_write_mask;
    end
    if (acc_wr && is_filter && req.paddr[2]) begin
      ext_mem_r[fidx] <= req.pwdata[15:0];
    end
  end

  assign match_valid = st_r.valid;
  assign match_any = st_r.any;
  assign match_index = st_r.index;
  assign match_vector = st_r.vector;

endmodule : can_acceptance_filter

// ==== pkg/accept_filter_pkg.sv ====
// Purpose: constants and carriers for the acceptance filter block
// Assumes: 10 MHz clk_sys, APB slave with 32-bit data, one word per register
// Notes: Notes on behaviour list follows
package accept_filter_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned num_filters = 16;
  localparam int unsigned num_masks = 3;

  // ----------------------------------------
  // register map (byte addresses, chosen)
  // ----------------------------------------
  localparam logic [11:0] std_id_base = 12'h000; // filter n at base + 8n
  localparam logic [11:0] ext_id_base = 12'h004;
  localparam logic [11:0] mask_sel_low_addr = 12'h080;
  localparam logic [11:0] mask_sel_high_addr = 12'h084;
  localparam logic [11:0] match_status_addr = 12'h088;

  // ----------------------------------------
  // field layout of the standard identifier register
  // ----------------------------------------
  localparam int unsigned std_id_msb = 15;
  localparam int unsigned std_id_lsb = 5;
  localparam int unsigned frame_sel_bit = 3;
  localparam logic [15:0] std_reg_write_mask = 16'hffeb; // bits 4 and 2 unimplemented
  localparam logic [15:0] mask_sel_reset = 16'h0000;

  // ----------------------------------------
  // mask source codes
  // ----------------------------------------
  localparam logic [1:0] src_mask0 = 2'h0;
  localparam logic [1:0] src_mask1 = 2'h1;
  localparam logic [1:0] src_mask2 = 2'h2;
  localparam logic [1:0] src_none = 2'h3;

  // one received identifier or one acceptance mask
  typedef struct packed {
    logic [10:0] std_id;
    logic [17:0] ext_id;
    logic extended; // for a mask: frame_type_match_enable
  } can_id_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : accept_filter_pkg

// ==== hdl/filter_compare.sv ====
// Purpose: compare one filter with a received identifier under its selected mask
// Assumes: purely combinational, one instance per filter
// Notes: a mask bit of one makes the identifier bit count in the compare
`timescale 1ns/10ps
module filter_compare (
  input wire logic [15:0] std_reg,
  input wire logic [15:0] ext_reg,
  input wire logic [1:0] mask_src,
  input wire accept_filter_pkg::can_id_t mask0,
  input wire accept_filter_pkg::can_id_t mask1,
  input wire accept_filter_pkg::can_id_t mask2,
  input wire accept_filter_pkg::can_id_t rx_id,
  output logic hit
);

  accept_filter_pkg::can_id_t sel_mask;
  accept_filter_pkg::can_id_t flt;

  // ----------------------------------------
  // filter fields and mask choice
  // ----------------------------------------
  always_comb begin
    flt.std_id = std_reg[accept_filter_pkg::std_id_msb:accept_filter_pkg::std_id_lsb];
    flt.ext_id = {std_reg[1:0], ext_reg};
    flt.extended = std_reg[accept_filter_pkg::frame_sel_bit];
    unique case (mask_src)
      accept_filter_pkg::src_mask0: sel_mask = mask0;
      accept_filter_pkg::src_mask1: sel_mask = mask1;
      accept_filter_pkg::src_mask2: sel_mask = mask2;
      accept_filter_pkg::src_none: sel_mask = '0;
    endcase
  end

  // every masked bit must agree; frame type only when the mask asks for it
  always_comb begin
    hit = (((flt.std_id ^ rx_id.std_id) & sel_mask.std_id) == 11'h000) &&
          (((flt.ext_id ^ rx_id.ext_id) & sel_mask.ext_id) == 18'h00000) &&
          (!sel_mask.extended || (flt.extended == rx_id.extended));
  end

endmodule : filter_compare

// ==== bench/can_acceptance_filter_monitor.sv ====
// Purpose: port checks for can_acceptance_filter
// Assumes: one clock, srst synchronous and active high
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
module can_acceptance_filter_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic rx_valid,
  input wire logic match_valid,
  input wire logic match_any,
  input wire logic [3:0] match_index,
  input wire logic [15:0] match_vector
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // a read access phase, and one received identifier
  sequence s_rd; psel && penable && !pwrite; endsequence
  sequence s_rx; rx_valid; endsequence
  a_result_next: assert property (s_rx |=> match_valid)
    else $error("no result after id");
  a_quiet_hold: assert property (!rx_valid |=> !match_valid && $stable(match_vector))
    else $error("result moved without id");
  a_any_vector: assert property (match_valid |-> match_any == (match_vector != 16'h0))
    else $error("any flag disagrees with vector");
  a_lowest_index: assert property (match_any |-> match_vector[match_index] &&
    (match_vector & ((16'h1 << match_index) - 16'h1)) == 16'h0) else $error("index not lowest");
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("access not answered");
  a_std_gaps: assert property (s_rd ##0 (paddr < 12'h080 && !paddr[2]) |->
    !prdata[4] && !prdata[2]) else $error("gap bit read as one");
  a_upper_zero: assert property (s_rd ##0 (paddr != 12'h088) |-> prdata[31:16] == 16'h0)
    else $error("upper half not zero");
  a_reset_clear: assert property (disable iff (1'b0) srst |=> !match_valid && !match_any &&
    match_vector == 16'h0) else $error("result not cleared by reset");
endmodule : can_acceptance_filter_monitor
bind can_acceptance_filter can_acceptance_filter_monitor u_mon (.clk_sys, .srst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .rx_valid, .match_valid, .match_any,
  .match_index, .match_vector);

// ==== bench/rx_source.sv ====
// Purpose: receive path model handing identifiers to the filter
// Assumes: one go pulse per identifier, gap adds 0 to 3 idle cycles
// Notes: rx_id carries inverted junk between identifiers
`timescale 1ns/10ps
module rx_source (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [1:0] gap,
  input wire accept_filter_pkg::can_id_t id_in,
  output logic rx_valid,
  output accept_filter_pkg::can_id_t rx_id
);
  logic [2:0] cnt_r = 3'h0;
  accept_filter_pkg::can_id_t hold_r;
  initial {rx_valid, rx_id} = '0;
  // count down the gap, then show the id for one cycle; idle id alternates between its inverse and the id itself
  always @(posedge clk_sys) begin
    if (go) cnt_r <= {1'b0, gap} + 3'h1;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    if (go) hold_r <= id_in;
    rx_valid <= cnt_r == 3'h1 && !go;
    rx_id <= (cnt_r == 3'h1) ? hold_r : ~rx_id;
  end
endmodule : rx_source

// ==== bench/test_can_acceptance_filter.sv ====
// Purpose: self-checking bench for can_acceptance_filter
// Assumes: 10 MHz clock, zero-wait APB, xorshift seed 35
// Notes: ids come from a stored filter, sometimes with one bit flipped
`timescale 1ns/10ps
module test_can_acceptance_filter;
  logic clk_sys = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic er, pready, pslverr, rx_valid, match_valid, match_any;
  logic [1:0] gap = 2'h0, ms [16];
  logic [3:0] match_index, ix;
  logic [11:0] paddr = 12'h0;
  logic [15:0] match_vector, ev, sr [16], xr [16];
  logic [31:0] pwdata = 32'h0, prdata, rd, w, sel, seed = 32'h23;
  accept_filter_pkg::can_id_t mk [3] = '{default: '0}, idn = '0, rx_id;
  int fail_count = 0, tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  can_acceptance_filter u_dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mask0(mk[0]), .mask1(mk[1]), .mask2(mk[2]), .rx_valid,
    .rx_id, .match_valid, .match_any, .match_index, .match_vector);
  rx_source u_src (.clk_sys, .go, .gap, .id_in(idn), .rx_valid, .rx_id);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // masked compare of every filter; code 3 means no mask at all
  function automatic logic [15:0] exp_vec();
    logic [15:0] e;
    accept_filter_pkg::can_id_t m;
    for (int k = 0; k < 16; k++) begin
      m = mk[ms[k] % 3];
      e[k] = ms[k] == 2'h3 || (((sr[k][15:5] ^ idn.std_id) & m.std_id) == 11'h0 &&
        (({sr[k][1:0], xr[k]} ^ idn.ext_id) & m.ext_id) == 18'h0 &&
        (!m.extended || sr[k][3] == idn.extended));
    end
    return e;
  endfunction : exp_vec
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask : apb
  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // watchdog: the run needs about 1250 cycles
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, accept_filter_pkg::mask_sel_low_addr, 32'h0);
    check("msel_reset", rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped", {er, rd[30:0]}, 32'h80000000);
    for (int k = 0; k < 16; k++) begin
      w = rnd();
      {sr[k], xr[k]} = w;
      apb(1'b1, 12'(8 * k), {16'hffff, sr[k]});
      apb(1'b1, 12'(8 * k + 4), {16'hffff, xr[k]});
      apb(1'b0, 12'(8 * k), 32'h0);
      check("std_reg", rd, {16'h0, sr[k] & 16'hffeb});
      apb(1'b0, 12'(8 * k + 4), 32'h0);
      check("ext_reg", rd, {16'h0, xr[k]});
    end
    // first round sets every mask code; odd rounds avoid code 3 to allow misses
    for (int r = 0; r < 48; r++) begin
      for (int k = 0; k < 16; k++) begin
        w = rnd();
        ms[k] = (r == 0) ? k[1:0] : (r[0] && w[1:0] == 2'h3) ? 2'h0 : w[1:0];
        sel[2 * k +: 2] = ms[k];
      end
      for (int i = 0; i < 3; i++) begin
        w = rnd();
        mk[i] <= w[29:0];
      end
      apb(1'b1, accept_filter_pkg::mask_sel_low_addr, {16'h0, sel[15:0]});
      apb(1'b1, accept_filter_pkg::mask_sel_high_addr, {16'h0, sel[31:16]});
      apb(1'b0, accept_filter_pkg::mask_sel_low_addr, 32'h0);
      check("msel_low", rd, {16'h0, sel[15:0]});
      apb(1'b0, accept_filter_pkg::mask_sel_high_addr, 32'h0);
      check("msel_high", rd, {16'h0, sel[31:16]});
      w = rnd();
      idn <= {sr[w[7:4]][15:5], sr[w[7:4]][1:0], xr[w[7:4]], sr[w[7:4]][3]} ^
        (w[8] ? 30'h1 << w[13:9] : 30'h0);
      {go, gap} <= {1'b1, w[1:0]};
      @(posedge clk_sys);
      go <= 1'b0;
      for (int i = 0; i < 12 && match_valid !== 1'b1; i++) @(negedge clk_sys);
      ev = exp_vec();
      ix = 4'h0;
      for (int k = 15; k >= 0; k--) if (ev[k]) ix = 4'(k);
      check("match_valid", {31'h0, match_valid}, 32'h1);
      check("match_vector", {16'h0, match_vector}, {16'h0, ev});
      check("match_any", {31'h0, match_any}, {31'h0, |ev});
      check("match_index", {28'h0, match_index}, {28'h0, ix});
      // the status word must mirror the held result until the next identifier
      apb(1'b0, accept_filter_pkg::match_status_addr, 32'h0);
      check("match_status", rd, {ev, 10'h000, |ev, 1'b0, ix});
      @(posedge clk_sys);
    end
    print_verdict();
  end
endmodule : test_can_acceptance_filter
